/* itb_map.svh */
// Register offsets, field positions, reset values and timing counts of the interrupt block.
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------------
`define ITB_OFS_ENABLE   8'h00
`define ITB_OFS_FLAGS    8'h04
`define ITB_OFS_EDGE     8'h08
`define ITB_OFS_SRCFLAG  8'h0C
`define ITB_OFS_SRCEN    8'h10
`define ITB_OFS_PSC0     8'h14
`define ITB_OFS_PSC1     8'h18
`define ITB_OFS_TBCTL0   8'h1C
`define ITB_OFS_TBCTL1   8'h20
`define ITB_OFS_PINCFG   8'h24
`define ITB_OFS_STATUS   8'h28
`define ITB_NUM_REGS     11

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ITB_GLOBAL_BIT   10
`define ITB_TB_RUN_BIT   7
`define ITB_MF0_MASK     10'h00F
`define ITB_MF1_MASK     10'h0F0
`define ITB_MF2_MASK     10'h300

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define ITB_RST_REG8     8'h00
`define ITB_RST_FLAGS    10'h000
`define ITB_SYS_DIV      4
`define ITB_TB_MIN_EXP   8

`endif

/* itb_pkg.sv */
// Types used by the interrupt module.
package itb_pkg;
  typedef enum logic [3:0] {
    ITB_VEC_EXT0 = 4'h0,
    ITB_VEC_EXT1 = 4'h1,
    ITB_VEC_EXT2 = 4'h2,
    ITB_VEC_CMP  = 4'h3,
    ITB_VEC_MF0  = 4'h4,
    ITB_VEC_MF1  = 4'h5,
    ITB_VEC_MF2  = 4'h6,
    ITB_VEC_ADC  = 4'h7,
    ITB_VEC_TB0  = 4'h8,
    ITB_VEC_TB1  = 4'h9
  } itb_vector_e;
  typedef logic [9:0] itb_flags_t;
endpackage

/* itb_tick_if.sv */
// Control and overflow link between the interrupt logic and one time-base unit.
`timescale 1ns/1ps
`default_nettype none
interface itb_tick_if;
  logic       run;
  logic [1:0] source;
  logic [2:0] period;
  logic       overflow;
  modport unit (input run, input source, input period, output overflow);
  modport ctrl (output run, output source, output period, input overflow);
endinterface
`default_nettype wire

/* itb_time_base.sv */
// One time-base unit: prescaler clock selection and power-of-two period divider.
`timescale 1ns/1ps
`default_nettype none
`include "itb_map.svh"
module itb_time_base #(
  parameter int CNT_W = 15
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic low_speed_tick,
  itb_tick_if.unit  link
);
  logic [1:0]       quarter;
  logic [CNT_W-1:0] count;
  logic             ovf;

  // ----------------------------------------------------------------------
  // Prescaler clock enable
  // ----------------------------------------------------------------------
  // The slow sources are enables, so the divider never leaves the system clock.
  wire       sys4_tick = (quarter == 2'(`ITB_SYS_DIV - 1));
  wire       psc_tick  = link.source[1] ? low_speed_tick :
                         link.source[0] ? sys4_tick : 1'b1;
  wire [CNT_W-1:0] limit = {CNT_W{1'b1}} >> (3'h7 - link.period);
  wire       hit       = link.run && psc_tick && (count == limit);

  // Free-running quarter divider for the system clock divided by four.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end

  // The divider is held at zero while stopped, so enabling restarts a period.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
      ovf   <= 1'b0;
    end
    else
    begin
      ovf <= hit;
      if (!link.run || hit)
        count <= '0;
      else if (psc_tick)
        count <= count + 1'b1;
    end
  end

  assign link.overflow = ovf;

  a_stopped_idle: assert property (@(posedge clock) disable iff (!rstn)
    !link.run |=> (count == '0) && !ovf)
    else $error("stopped time base still counts");
endmodule
`default_nettype wire

/* itb_irq_top.sv */
// Interrupt request logic with two time-base units, reached over APB.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "itb_map.svh"
// Notes on behaviour
// - Chosen pin edge sets external line flag.
// - External vector needs global, line enable, stack.
// - Pin needs enable, routing and input direction.
// - Chosen pull-up stays active in interrupt use.
// - Edge select: rising, falling, both, or off.
// - Field codes 00 off,01 rise,10 fall,11 both.
// - External service clears line flag and global.
// - Comparator change sets flag; vector needs enables.
// - Comparator service clears its flag and global.
// - Three combined interrupts from timer, voltage, memory.
// - Source flag rising sets combined flag.
// - Combined service leaves source flags for software.
// - Conversion end sets flag; vector needs enables.
// - Conversion service clears its flag and global.
// - Time-base overflow sets flag; vector needs enables.
// - Time-base service clears its flag and global.
// - Clock source: 00 system, 01 quarter, 1x slow.
// - Control bit 7 runs time base; resets zero.
// - Period is two to eight-plus-code clocks.
// - Each timer gives A and P match requests.
// - Timer vector needs own, combined, global enables.
// - Timer service clears combined flag and global only.
// - Unused prescaler and control bits read zero.
// - Cleared global enable blocks every vector.
// - Any flag rising wakes the device.
// - Return-from-interrupt sets global enable again.
module itb_irq_top #(
  parameter int TIMERS = 4
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        ext_irq_pins,
  input  wire logic              comparator_out,
  input  wire logic              conv_done,
  input  wire logic [TIMERS-1:0] timer_match_a,
  input  wire logic [TIMERS-1:0] timer_match_p,
  input  wire logic              low_voltage_event,
  input  wire logic              eeprom_done,
  input  wire logic              low_speed_tick,
  input  wire logic              stack_full,
  input  wire logic              irq_ack,
  input  wire logic              return_from_irq,
  output logic                   irq_req,
  output logic      [3:0]        irq_vector,
  output logic                   wake,
  output logic      [2:0]        ext_pull_up
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic                global_irq_enable;
  itb_pkg::itb_flags_t irq_en;
  itb_pkg::itb_flags_t flags;
  logic [5:0]          edge_select_reg;
  logic [9:0]          src_flags;
  logic [9:0]          src_en;
  logic [1:0]          psc_sel [2];
  logic [3:0]          tb_ctl  [2];
  logic [2:0]          pin_route;
  logic [2:0]          pin_input;
  logic [2:0]          pull_sel;
  logic [2:0]          pin_prev;
  logic                cmp_prev;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire [5:0] reg_idx  = paddr[7:2];
  wire       addr_ok  = (reg_idx < 6'(`ITB_NUM_REGS)) && (paddr[1:0] == 2'h0);
  wire       setup    = psel && !penable;
  wire       wr_fire  = psel && penable && pready && pwrite && addr_ok;
  wire       wr_en    = wr_fire && (paddr == `ITB_OFS_ENABLE);
  wire       wr_flags = wr_fire && (paddr == `ITB_OFS_FLAGS);
  wire       wr_edge  = wr_fire && (paddr == `ITB_OFS_EDGE);
  wire       wr_srcf  = wr_fire && (paddr == `ITB_OFS_SRCFLAG);
  wire       wr_srce  = wr_fire && (paddr == `ITB_OFS_SRCEN);
  wire       wr_psc0  = wr_fire && (paddr == `ITB_OFS_PSC0);
  wire       wr_psc1  = wr_fire && (paddr == `ITB_OFS_PSC1);
  wire       wr_tb0   = wr_fire && (paddr == `ITB_OFS_TBCTL0);
  wire       wr_tb1   = wr_fire && (paddr == `ITB_OFS_TBCTL1);
  wire       wr_pin   = wr_fire && (paddr == `ITB_OFS_PINCFG);

  // ----------------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------------
  logic [2:0] ext_edge;
  logic [9:0] src_set;
  logic [1:0] tb_ovf;
  genvar g;

  // Each line only listens when enabled, routed to the pin and set as input.
  generate
    for (g = 0; g < 3; g++)
    begin : g_ext
      wire active = irq_en[g] && pin_route[g] && pin_input[g];
      wire rise   = ext_irq_pins[g] && !pin_prev[g];
      wire fall   = !ext_irq_pins[g] && pin_prev[g];
      // Bit 0 of the field picks rising, bit 1 falling; zero turns the line off.
      assign ext_edge[g] = active && ((edge_select_reg[2*g] && rise) ||
                                      (edge_select_reg[2*g+1] && fall));
    end
  endgenerate

  // Timer matches occupy pairs of source bits, P match low, A match high.
  generate
    for (g = 0; g < TIMERS; g++)
    begin : g_timer
      assign src_set[2*g]   = timer_match_p[g];
      assign src_set[2*g+1] = timer_match_a[g];
    end
  endgenerate
  assign src_set[8] = low_voltage_event;
  assign src_set[9] = eeprom_done;

  wire        cmp_change = comparator_out != cmp_prev;
  wire [9:0]  src_rise   = src_set & ~src_flags;
  wire [2:0]  mf_set     = {|(src_rise & `ITB_MF2_MASK),
                            |(src_rise & `ITB_MF1_MASK),
                            |(src_rise & `ITB_MF0_MASK)};
  wire [9:0]  src_live   = src_flags & src_en;
  wire [2:0]  mf_ready   = {|(src_live & `ITB_MF2_MASK),
                            |(src_live & `ITB_MF1_MASK),
                            |(src_live & `ITB_MF0_MASK)};
  wire [9:0]  set_vec    = {tb_ovf, conv_done, mf_set, cmp_change, ext_edge};

  // ----------------------------------------------------------------------
  // Vector selection and service
  // ----------------------------------------------------------------------
  function automatic logic [3:0] first_set(input logic [9:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 9; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction

  wire [9:0] qual     = {3'b111, mf_ready, 4'hF};
  wire [9:0] pending  = flags & irq_en & qual;
  wire       ack_take = irq_ack && irq_req;
  wire [9:0] ack_clr  = ack_take ? (10'h001 << irq_vector) : 10'h000;
  // A new event in the clearing cycle wins over both the service and the write.
  wire [9:0] next_flags = ((wr_flags ? pwdata[9:0] : flags) & ~ack_clr) | set_vec;
  wire [9:0] next_src   = (wr_srcf ? pwdata[9:0] : src_flags) | src_set;
  wire       next_global = ack_take        ? 1'b0 :
                           return_from_irq ? 1'b1 :
                           wr_en           ? pwdata[`ITB_GLOBAL_BIT] :
                           global_irq_enable;
  wire       next_irq_req = global_irq_enable && !stack_full &&
                            (|pending) && !ack_take;
  wire       next_wake    = |(next_flags & ~flags) || |(next_src & ~src_flags);

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [31:0] rd_table [`ITB_NUM_REGS];
  assign rd_table[0]  = {21'h0, global_irq_enable, irq_en};
  assign rd_table[1]  = {22'h0, flags};
  assign rd_table[2]  = {26'h0, edge_select_reg};
  assign rd_table[3]  = {22'h0, src_flags};
  assign rd_table[4]  = {22'h0, src_en};
  assign rd_table[5]  = {30'h0, psc_sel[0]};
  assign rd_table[6]  = {30'h0, psc_sel[1]};
  assign rd_table[7]  = {24'h0, tb_ctl[0][3], 4'h0, tb_ctl[0][2:0]};
  assign rd_table[8]  = {24'h0, tb_ctl[1][3], 4'h0, tb_ctl[1][2:0]};
  assign rd_table[9]  = {23'h0, pull_sel, pin_input, pin_route};
  assign rd_table[10] = {26'h0, irq_req, irq_vector, global_irq_enable};
  wire [31:0] rd_word = addr_ok ? rd_table[reg_idx[3:0]] : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Time-base units
  // ----------------------------------------------------------------------
  itb_tick_if tb_link [2] ();
  generate
    for (g = 0; g < 2; g++)
    begin : g_tb
      assign tb_link[g].run    = tb_ctl[g][3];
      assign tb_link[g].source = psc_sel[g];
      assign tb_link[g].period = tb_ctl[g][2:0];
      assign tb_ovf[g]         = tb_link[g].overflow;
      itb_time_base #(.CNT_W(15)) u_tb (
        .clock          (clock),
        .rstn           (rstn),
        .low_speed_tick (low_speed_tick),
        .link           (tb_link[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Bus answer: one wait-free access phase, data captured in the setup cycle.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata  <= rd_word;
        pslverr <= !addr_ok;
      end
    end
  end

  // Flags, global enable and the request toward the core.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      flags             <= `ITB_RST_FLAGS;
      src_flags         <= `ITB_RST_FLAGS;
      global_irq_enable <= 1'b0;
      irq_req           <= 1'b0;
      irq_vector        <= 4'h0;
      wake              <= 1'b0;
    end
    else
    begin
      flags             <= next_flags;
      src_flags         <= next_src;
      global_irq_enable <= next_global;
      irq_req           <= next_irq_req;
      irq_vector        <= first_set(pending);
      wake              <= next_wake;
    end
  end

  // Software configuration; the time-base run bits reset to stopped.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_en          <= `ITB_RST_FLAGS;
      edge_select_reg <= 6'h00;
      src_en          <= `ITB_RST_FLAGS;
      psc_sel[0]      <= 2'h0;
      psc_sel[1]      <= 2'h0;
      tb_ctl[0]       <= 4'h0;
      tb_ctl[1]       <= 4'h0;
      pin_route       <= 3'h0;
      pin_input       <= 3'h0;
      pull_sel        <= 3'h0;
    end
    else
    begin
      if (wr_en)   irq_en          <= pwdata[9:0];
      if (wr_edge) edge_select_reg <= pwdata[5:0];
      if (wr_srce) src_en          <= pwdata[9:0];
      if (wr_psc0) psc_sel[0]      <= pwdata[1:0];
      if (wr_psc1) psc_sel[1]      <= pwdata[1:0];
      if (wr_tb0)  tb_ctl[0]       <= {pwdata[`ITB_TB_RUN_BIT], pwdata[2:0]};
      if (wr_tb1)  tb_ctl[1]       <= {pwdata[`ITB_TB_RUN_BIT], pwdata[2:0]};
      if (wr_pin)
      begin
        pin_route <= pwdata[2:0];
        pin_input <= pwdata[5:3];
        pull_sel  <= pwdata[8:6];
      end
    end
  end

  // Edge history and pull-up drive; pull-ups follow the setting in every pin role.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_prev    <= 3'h0;
      cmp_prev    <= 1'b0;
      ext_pull_up <= 3'h0;
    end
    else
    begin
      pin_prev    <= ext_irq_pins;
      cmp_prev    <= comparator_out;
      ext_pull_up <= pull_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_service_clears_global: assert property (@(posedge clock) disable iff (!rstn)
    ack_take |=> !global_irq_enable)
    else $error("service left global enable set");

  a_service_clears_flag: assert property (@(posedge clock) disable iff (!rstn)
    ack_take && !set_vec[irq_vector] && !wr_flags |=> !flags[$past(irq_vector)])
    else $error("serviced flag not cleared");

  a_global_gates_req: assert property (@(posedge clock) disable iff (!rstn)
    irq_req |-> $past(global_irq_enable) && !$past(stack_full))
    else $error("request raised while blocked");

  a_return_sets_global: assert property (@(posedge clock) disable iff (!rstn)
    return_from_irq && !ack_take |=> global_irq_enable)
    else $error("return did not restore global enable");

  a_ext_edge_flag: assert property (@(posedge clock) disable iff (!rstn)
    ext_edge[0] |=> flags[0] ##1 (flags[0] || $past(ack_take) || $past(wr_flags)))
    else $error("external edge did not set flag");

  a_cmp_change_flag: assert property (@(posedge clock) disable iff (!rstn)
    (comparator_out != cmp_prev) |=> flags[itb_pkg::ITB_VEC_CMP])
    else $error("comparator change lost");

  a_combined_keeps_src: assert property (@(posedge clock) disable iff (!rstn)
    ack_take && !wr_srcf |=> (src_flags & $past(src_flags)) == $past(src_flags))
    else $error("service cleared a source flag");

  a_wake_on_rise: assert property (@(posedge clock) disable iff (!rstn)
    (flags & ~$past(flags)) != 10'h000 |-> wake)
    else $error("flag rise without wake");

  a_disabled_line_quiet: assert property (@(posedge clock) disable iff (!rstn)
    edge_select_reg[1:0] == 2'b00 |-> !ext_edge[0])
    else $error("disabled line produced an edge");
endmodule
`default_nettype wire

/* itb_core_model.sv */
// Behavioural core side: accepts interrupt vectors after a chosen delay.
`timescale 1ns/1ps
`default_nettype none
module itb_core_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_vector,
  input  wire logic [3:0] delay,
  output logic            irq_ack,
  output logic      [3:0] served,
  output logic      [7:0] n_served
);
  logic [3:0] wait_cnt;

  // One acknowledge pulse per request; holding it would serve a second vector.
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
      served   <= 4'h0;
      n_served <= 8'h00;
    end
    else
    begin
      irq_ack <= 1'b0;
      if (irq_ack)
      begin
        served   <= irq_vector;
        n_served <= n_served + 8'h01;
      end
      if (!irq_req || irq_ack)
        wait_cnt <= 4'h0;
      else if (wait_cnt >= delay)
        irq_ack <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
endmodule
`default_nettype wire

/* tb_interrupt_sources_and_time_base.sv */
// Self-checking bench of the interrupt block with its time bases.
`timescale 1ns/1ps
`default_nettype none
`include "itb_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_interrupt_sources_and_time_base;
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, n_srv;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  pins, pull;
  logic        cmp, conv, low_v, eep, slow, stk, ack, ret, irq_req, wake;
  logic [3:0]  vec, served, dly, match_a, match_p;
  int          n_errors, n_checks, cyc, t0, n_wake;
  logic [7:0]  ofs [4] = '{`ITB_OFS_PSC0, `ITB_OFS_PSC1, `ITB_OFS_TBCTL0, `ITB_OFS_TBCTL1};

  itb_irq_top #(.TIMERS(4)) itb_irq_top_i (.clock(clock), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pins(pins), .comparator_out(cmp),
    .conv_done(conv), .timer_match_a(match_a), .timer_match_p(match_p),
    .low_voltage_event(low_v),
    .eeprom_done(eep), .low_speed_tick(slow), .stack_full(stk), .irq_ack(ack),
    .return_from_irq(ret), .irq_req(irq_req), .irq_vector(vec), .wake(wake),
    .ext_pull_up(pull));
  itb_core_model itb_core_model_i (.clock(clock), .rstn(rstn), .irq_req(irq_req),
    .irq_vector(vec), .delay(dly), .irq_ack(ack), .served(served), .n_served(n_srv));

  // ----------------------------------------------------------------------
  // Clock, cycle count, slow tick every eighth cycle, wake pulse count
  // ----------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    slow <= (cyc % 8 == 7);
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
  end

  // ----------------------------------------------------------------------
  // APB master and helpers
  // ----------------------------------------------------------------------
  // The request is held until pready is seen at a rising edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      `CHK("pready", 1'b1, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask
  // Waits for one vector, checks it, that nothing follows, then returns.
  task automatic serve(input logic [3:0] v, input logic [9:0] rest);
    logic [7:0] n0;
    n0 = n_srv;
    for (int k = 0; k < 40 && n_srv == n0; k++)
      @(posedge clock);
    `CHK("vector", v, served)
    repeat (4) @(posedge clock);
    `CHK("held_off", 1'b0, irq_req)
    rd(`ITB_OFS_FLAGS);
    `CHK("flags_left", rest, rdata[9:0])
    rd(`ITB_OFS_STATUS);
    `CHK("global_off", 1'b0, rdata[0])
    ret <= 1'b1;
    @(posedge clock);
    ret <= 1'b0;
  endtask
  // Runs one time base from a stopped start and times its first overflow.
  task automatic tb_period(input logic [7:0] psc, tbc, input logic [1:0] s,
                           input logic [2:0] p, input int b, input int n);
    wr(tbc, 32'h0);
    wr(`ITB_OFS_FLAGS, 32'h0);
    wr(psc, {30'h0, s});
    wr(tbc, {24'h0, 5'h10, p});
    t0 = cyc;
    while (rdata[b] !== 1'b1 && cyc - t0 < n + 64)
      rd(`ITB_OFS_FLAGS);
    `CHK("tb_period", 1'b1, (cyc - t0 >= n - 4) && (cyc - t0 <= n + 16))
    wr(tbc, 32'h0);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pins, cmp, conv, low_v, eep} = '0;
    {slow, stk, ret, match_a, match_p, dly, cyc, n_wake, n_errors, n_checks} = '0;
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    // Reset values and which bits keep a written one.
    for (int i = 0; i < 4; i++)
    begin
      rd(ofs[i]);
      `CHK("ctl_reset", 32'h0, rdata)
      wr(ofs[i], 32'hFFFF_FFFF);
      rd(ofs[i]);
      `CHK("ctl_bits", (i < 2) ? 32'h3 : 32'h87, rdata)
      wr(ofs[i], 32'h0);
    end
    rd(8'h2C);
    `CHK("unmapped", 1'b1, rerr)
    // Every edge code on line 0, rise then fall; no vectoring.
    wr(`ITB_OFS_PINCFG, 32'h17F);
    // The setting lands at the write edge and reaches the pin one edge later.
    repeat (2) @(posedge clock);
    `CHK("pull_up", 3'b101, pull)
    wr(`ITB_OFS_ENABLE, 32'h7);
    for (int c = 0; c < 4; c++)
    begin
      wr(`ITB_OFS_EDGE, 32'(c));
      for (int e = 0; e < 2; e++)
      begin
        wr(`ITB_OFS_FLAGS, 32'h0);
        pins[0] <= ~pins[0];
        repeat (3) @(posedge clock);
        rd(`ITB_OFS_FLAGS);
        `CHK("edge_flag", c[e], rdata[0])
      end
    end
    // Line 1 with its pin set as an output must not trigger.
    wr(`ITB_OFS_PINCFG, 32'h16F);
    wr(`ITB_OFS_EDGE, 32'hC);
    pins[1] <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`ITB_OFS_FLAGS);
    `CHK("dir_block", 1'b0, rdata[1])
    // Full stack blocks, then pending vectors come out by priority.
    wr(`ITB_OFS_EDGE, 32'h0);
    wr(`ITB_OFS_FLAGS, 32'h388);
    stk <= 1'b1;
    wr(`ITB_OFS_ENABLE, 32'h78F);
    repeat (6) @(posedge clock);
    `CHK("stack_block", 1'b0, irq_req)
    stk <= 1'b0;
    serve(4'h3, 10'h380);
    dly <= 4'h5;
    serve(4'h7, 10'h300);
    serve(4'h8, 10'h200);
    serve(4'h9, 10'h000);
    // Hardware events set flags and wake with every enable off.
    wr(`ITB_OFS_ENABLE, 32'h0);
    t0 = n_wake;
    conv <= 1'b1;
    @(posedge clock);
    conv <= 1'b0;
    cmp <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`ITB_OFS_FLAGS);
    `CHK("event_flags", 10'h088, rdata[9:0])
    `CHK("wake_count", t0 + 2, n_wake)
    // Grouped sources: no vector without a source enable, service keeps sources.
    wr(`ITB_OFS_FLAGS, 32'h0);
    wr(`ITB_OFS_ENABLE, 32'h470);
    match_a[0] <= 1'b1;
    match_p[3] <= 1'b1;
    low_v <= 1'b1;
    eep <= 1'b1;
    @(posedge clock);
    {match_a, match_p, low_v, eep} <= '0;
    repeat (6) @(posedge clock);
    `CHK("src_en_block", 1'b0, irq_req)
    rd(`ITB_OFS_SRCFLAG);
    `CHK("src_flags", 32'h342, rdata)
    rd(`ITB_OFS_FLAGS);
    `CHK("mf_flags", 10'h070, rdata[9:0])
    wr(`ITB_OFS_SRCEN, 32'h342);
    serve(4'h4, 10'h060);
    serve(4'h5, 10'h040);
    serve(4'h6, 10'h000);
    rd(`ITB_OFS_SRCFLAG);
    `CHK("src_kept", 32'h342, rdata)
    wr(`ITB_OFS_SRCFLAG, 32'h0);
    wr(`ITB_OFS_ENABLE, 32'h0);
    // Time bases over every clock source and two periods.
    tb_period(`ITB_OFS_PSC0, `ITB_OFS_TBCTL0, 2'b00, 3'd1, 8, 512);
    tb_period(`ITB_OFS_PSC1, `ITB_OFS_TBCTL1, 2'b01, 3'd0, 9, 1024);
    tb_period(`ITB_OFS_PSC0, `ITB_OFS_TBCTL0, 2'b10, 3'd0, 8, 2048);
    tb_period(`ITB_OFS_PSC1, `ITB_OFS_TBCTL1, 2'b11, 3'd0, 9, 2048);
    wr(`ITB_OFS_FLAGS, 32'h0);
    repeat (300) @(posedge clock);
    rd(`ITB_OFS_FLAGS);
    `CHK("tb_stopped", 10'h000, rdata[9:0])
    end_sim();
  end

  // A hang counts as a mismatch; the full run needs well under this.
  initial
  begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
